// file: src/lbbc_pkg.sv
// package: constants for the led buck boundary controller
package lbbc_pkg;
  localparam int unsigned CLK_PERIOD_PS      = 8000;    // 125 mhz system clock
  localparam int unsigned BLANK_TIME_NS      = 370;     // sense blanking interval
  localparam int unsigned BLANK_CYCLES       = (BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
  localparam int unsigned MAX_FREQ_KHZ       = 175;     // conversion frequency ceiling
  localparam int unsigned MIN_PERIOD_NS      = (1000000 + MAX_FREQ_KHZ - 1) / MAX_FREQ_KHZ;
  localparam int unsigned MIN_PERIOD_CYCLES  = (MIN_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
  localparam int unsigned CNT_W              = 10;      // wide enough for the period count
  localparam int unsigned SYNC_STAGES        = 2;

  typedef enum logic [4:0] {
    LBBC_OFF_S     = 5'b0_0001,  // lockout, disabled or fault
    LBBC_ON_S      = 5'b0_0010,  // gate high, inductor charging
    LBBC_DISCH_S   = 5'b0_0100,  // gate low, inductor discharging
    LBBC_WAIT_S    = 5'b0_1000,  // mask released, waiting for a valley
    LBBC_HOLD_S    = 5'b1_0000   // valley seen, period not yet elapsed
  } lbbc_state_type;
endpackage : lbbc_pkg

// file: src/lbbc_sync.sv
// file: two-stage synchroniser bank for the comparator inputs
`timescale 1ns/100ps
module lbbc_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second; reset leaves all inputs inactive
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : lbbc_sync

// file: src/lbbc_core.sv
// file: cycle-by-cycle gate control for a boundary-conduction led buck converter
`timescale 1ns/100ps
module lbbc_core
#(
  parameter int unsigned BLANK_CNT  = lbbc_pkg::BLANK_CYCLES,
  parameter int unsigned PERIOD_CNT = lbbc_pkg::MIN_PERIOD_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic supply_startup_i,      // supply above startup threshold
  input  wire logic supply_lockout_i,      // supply below supply_stop_threshold
  input  wire logic dim_high_i,            // dimming input reads high
  input  wire logic dim_open_i,            // dimming input open
  input  wire logic mask_high_i,           // masking input above threshold
  input  wire logic mask_open_i,           // masking input open
  input  wire logic sense_peak_i,          // sense reached peak trip level
  input  wire logic short_circuit_trip_i,  // sense reached short-circuit level
  input  wire logic valley_i,              // valley seen on the switch node
  input  wire logic over_temp_i,           // junction above shutdown temperature
  output logic      gate_o,
  output logic      running_o,             // supply good and converter enabled
  output logic      short_fault_o,         // short circuit latched
  output logic      fault_o                // any fault currently stopping the gate
);
  import lbbc_pkg::*;

  localparam int unsigned NSYNC = 10;

  logic [NSYNC-1:0] raw_w;
  logic [NSYNC-1:0] syn_w;
  logic             startup_s;
  logic             lockout_s;
  logic             dim_high_s;
  logic             dim_open_s;
  logic             mask_high_s;
  logic             mask_open_s;
  logic             peak_s;
  logic             short_s;
  logic             valley_s;
  logic             hot_s;

  logic             supply_ok_q;
  logic             short_q;
  lbbc_state_type   state_q;
  lbbc_state_type   state_d;
  logic [CNT_W-1:0] blank_cnt_q;
  logic [CNT_W-1:0] period_cnt_q;
  logic             blank_done_w;
  logic             period_done_w;
  logic             enable_w;
  logic             turn_on_w;

  // every comparator crosses into the clock domain before use
  assign raw_w = {supply_startup_i, supply_lockout_i, dim_high_i, dim_open_i,
                  mask_high_i, mask_open_i, sense_peak_i, short_circuit_trip_i,
                  valley_i, over_temp_i};

  lbbc_sync #(
    .WIDTH (NSYNC)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (raw_w),
    .sync_o    (syn_w)
  );

  assign {startup_s, lockout_s, dim_high_s, dim_open_s, mask_high_s, mask_open_s,
          peak_s, short_s, valley_s, hot_s} = syn_w;

  // supply hysteresis: lockout wins, so a collapsing supply always stops
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      supply_ok_q <= 1'b0;
    end else if (lockout_s) begin
      supply_ok_q <= 1'b0;
    end else if (startup_s) begin
      supply_ok_q <= 1'b1;
    end
  end

  // short circuit stays latched until the supply drops below lockout
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      short_q <= 1'b0;
    end else if (short_s) begin
      short_q <= 1'b1;
    end else if (!supply_ok_q) begin
      short_q <= 1'b0;
    end
  end

  // open pins and over-temperature restart on their own once they clear
  assign fault_o  = dim_open_s | mask_open_s | hot_s | short_q;
  assign enable_w = supply_ok_q & ~dim_high_s & ~fault_o;

  assign blank_done_w  = (blank_cnt_q >= CNT_W'(BLANK_CNT));
  assign period_done_w = (period_cnt_q >= CNT_W'(PERIOD_CNT));

  // valley turn-on needs mask released and the minimum period elapsed
  assign turn_on_w = valley_s & ~mask_high_s & period_done_w;

  // a turn-on is the step into the on state; shared by the period counter and its check
  function automatic logic is_turn_on(input lbbc_state_type cur,
                                      input lbbc_state_type nxt);
    return (nxt == LBBC_ON_S) && (cur != LBBC_ON_S);
  endfunction : is_turn_on

  // cycle state: waits have no timeout, so the frequency has no lower bound
  always_comb begin
    state_d = state_q;
    case (state_q)
      LBBC_OFF_S: begin
        if (enable_w && period_done_w && !mask_high_s) begin
          state_d = LBBC_ON_S;
        end
      end
      LBBC_ON_S: begin
        if (blank_done_w && peak_s) begin
          state_d = LBBC_DISCH_S;
        end
      end
      LBBC_DISCH_S: begin
        if (!mask_high_s) begin
          state_d = LBBC_WAIT_S;
        end
      end
      LBBC_WAIT_S: begin
        if (mask_high_s) begin
          state_d = LBBC_DISCH_S;
        end else if (turn_on_w) begin
          state_d = LBBC_ON_S;
        end else if (valley_s) begin
          state_d = LBBC_HOLD_S;
        end
      end
      LBBC_HOLD_S: begin
        if (mask_high_s) begin
          state_d = LBBC_DISCH_S;
        end else if (period_done_w) begin
          state_d = LBBC_ON_S;
        end
      end
      default: begin
        state_d = LBBC_OFF_S;
      end
    endcase
    if (!enable_w) begin
      state_d = LBBC_OFF_S;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q <= LBBC_OFF_S;
    end else begin
      state_q <= state_d;
    end
  end

  // blanking counter restarts at each turn-on and saturates
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      blank_cnt_q <= '0;
    end else if (state_q != LBBC_ON_S) begin
      blank_cnt_q <= '0;
    end else if (!blank_done_w) begin
      blank_cnt_q <= blank_cnt_q + CNT_W'(1);
    end
  end

  // period counter restarts at each turn-on; saturated means ready
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      period_cnt_q <= CNT_W'(PERIOD_CNT);
    end else if (is_turn_on(state_q, state_d)) begin
      period_cnt_q <= CNT_W'(1);
    end else if (!period_done_w) begin
      period_cnt_q <= period_cnt_q + CNT_W'(1);
    end
  end

  // gate is registered from the next state, so it matches the state register and is low outside the on phase
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      gate_o    <= 1'b0;
      running_o <= 1'b0;
    end else begin
      gate_o    <= (state_d == LBBC_ON_S);
      running_o <= enable_w;
    end
  end

  assign short_fault_o = short_q;

  // gate is never high without the enable one cycle earlier
  a_gate_needs_enable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    gate_o |-> $past(enable_w))
    else $error("gate high while converter disabled");

  // dimming high forces the gate low on the next edge
  a_dim_stops_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    dim_high_s |=> !gate_o)
    else $error("gate pulse while dimming input high");

  // blanking counter starts from zero at every turn-on
  a_min_on_time: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(gate_o) && enable_w |-> blank_cnt_q == '0)
    else $error("blanking counter not cleared at turn-on");

  // no turn-on before the period counter completes
  a_period_limit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    is_turn_on(state_q, state_d) |-> period_done_w)
    else $error("turn-on before minimum period");

  // mask high blocks every turn-on, from the off state as well
  a_mask_blocks: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (mask_high_s && state_q != LBBC_ON_S) |=> !gate_o)
    else $error("turn-on while masking active");

  // a peak trip after blanking ends the on phase within one cycle
  a_peak_turns_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == LBBC_ON_S && blank_done_w && peak_s) |=> !gate_o)
    else $error("gate stayed on after peak trip");

  // short circuit latches and keeps the gate low
  a_short_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    short_s |=> short_q ##1 !gate_o)
    else $error("short circuit did not stop switching");

  // lockout drops the supply-good flag
  a_lockout_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    lockout_s |=> !supply_ok_q ##1 !gate_o)
    else $error("switching continued under lockout");

  // over-temperature shows as a fault and the gate goes low
  a_hot_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    hot_s |-> fault_o ##1 !gate_o)
    else $error("switching continued while over temperature");

  // a valley with the mask released and period elapsed turns the gate on
  a_valley_on: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == LBBC_WAIT_S && turn_on_w && enable_w) |=> gate_o)
    else $error("valley did not turn gate on");

  // startup seen without lockout sets the supply-good flag
  a_startup_enables: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (startup_s && !lockout_s) |=> supply_ok_q)
    else $error("supply good not set after startup");

  // supply good only ever rises on a startup indication without lockout
  a_supply_cause: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(supply_ok_q) |-> ($past(startup_s) && !$past(lockout_s)))
    else $error("supply good rose without startup");

  // once stopped, the supply stays off until startup is seen again
  a_no_early_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!supply_ok_q && !startup_s) |=> !supply_ok_q)
    else $error("supply good rose below startup");

  // enable shows up on the running flag one edge later
  a_running_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    enable_w |=> running_o)
    else $error("running flag missing while enabled");

  // dimming high clears the running flag
  a_dim_not_running: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    dim_high_s |=> !running_o)
    else $error("running flag set while dimming high");

  // from off, an enabled converter with mask low and period done turns on
  a_off_to_on: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == LBBC_OFF_S && enable_w && period_done_w && !mask_high_s) |=> gate_o)
    else $error("enabled converter did not start");

  // the gate stays on through the blanking interval, whatever the sense says
  a_blank_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == LBBC_ON_S && !blank_done_w && enable_w) |=> gate_o)
    else $error("gate dropped inside blanking");

  // without a peak trip the on phase continues
  a_on_waits_trip: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == LBBC_ON_S && !peak_s && enable_w) |=> gate_o)
    else $error("gate dropped without peak trip");

  // discharge never turns the gate on directly
  a_discharge_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == LBBC_DISCH_S) |=> !gate_o)
    else $error("gate on straight from discharge");

  // waiting without a valley keeps the gate off
  a_valley_needed: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == LBBC_WAIT_S && !valley_s) |=> !gate_o)
    else $error("turn-on without valley");

  // a remembered valley still waits for the period to elapse
  a_hold_waits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == LBBC_HOLD_S && !period_done_w) |=> !gate_o)
    else $error("turn-on from hold before minimum period");

  // a remembered valley turns on as soon as the period is done
  a_hold_turn_on: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == LBBC_HOLD_S && period_done_w && !mask_high_s && enable_w) |=> gate_o)
    else $error("hold did not turn on after period");

  // each turn-on restarts the period count, so spacing is measured from it
  a_period_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(gate_o) |-> (period_cnt_q == CNT_W'(1)))
    else $error("period counter not restarted at turn-on");

  // open dimming input is a fault and stops the gate
  a_open_dim_fault: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    dim_open_s |-> fault_o ##1 !gate_o)
    else $error("open dimming input did not stop switching");

  // open masking input is a fault and stops the gate
  a_open_mask_fault: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    mask_open_s |-> fault_o ##1 !gate_o)
    else $error("open masking input did not stop switching");

  // with every fault source gone the fault flag drops, so operation resumes
  a_fault_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!dim_open_s && !mask_open_s && !hot_s && !short_q) |-> !fault_o)
    else $error("fault flag stuck after causes cleared");

  // the off state never leaves the gate high
  a_off_gate_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == LBBC_OFF_S) |-> !gate_o)
    else $error("gate high in off state");
endmodule : lbbc_core

// file: tb/lbbc_load.sv
// behavioural model of the switch, inductor and led string around the gate
`timescale 1ns/100ps
module lbbc_load (
  input  wire logic       sys_clk_i,
  input  wire logic       gate_i,
  input  wire logic [7:0] charge_len_i,  // on cycles until the sense peak trips
  input  wire logic [7:0] ring_len_i,    // cycles of freewheel before the node rings
  input  wire logic       mask_stuck_i,  // bench holds the masking level up
  output logic            sense_peak_o,
  output logic            mask_high_o,
  output logic            valley_o,
  output logic [7:0]      valley_age_o
);
  logic [7:0] on_cnt_q  = 8'h00;
  logic [7:0] off_cnt_q = 8'h00;
  logic       gate_on;
  // an unknown gate before the first reset edge counts as off, so no counter goes unknown
  assign gate_on = (gate_i === 1'b1);
  // current ramps while the gate is on; the off count saturates so a long stop never wraps
  always_ff @(posedge sys_clk_i) begin
    on_cnt_q     <= gate_on ? on_cnt_q + 8'h01 : 8'h00;
    off_cnt_q    <= gate_on ? 8'h00 : (off_cnt_q == 8'hff ? off_cnt_q : off_cnt_q + 8'h01);
    valley_age_o <= valley_o ? valley_age_o + 8'h01 : 8'h00;
  end
  // peak stays tripped until turn-off; a valley only after the mask level has fallen
  assign sense_peak_o = gate_on && (on_cnt_q >= charge_len_i);
  assign mask_high_o  = !gate_on && ((off_cnt_q < ring_len_i) || mask_stuck_i);
  assign valley_o     = !gate_on && !mask_high_o && (off_cnt_q >= ring_len_i + 8'h03);
endmodule : lbbc_load

// file: tb/lbbc_bench.sv
// self-checking bench for the led buck boundary controller
`timescale 1ns/100ps
module lbbc_bench;
  import lbbc_pkg::*;
  localparam int unsigned BLANK  = 3;  // short counts keep the run brief
  localparam int unsigned PERIOD = 8;
  logic        sys_clk_i, rst_n_i, startup, short_trip, dim_high, mask_stuck, watch;
  logic [3:0]  flt;  // dim open, mask open, over temp, lockout
  logic        gate, running, short_fault, fault, peak, mask_high, valley;
  logic [7:0]  charge_len, ring_len, valley_age;
  logic [15:0] lfsr;
  logic        in_cycle = 1'b0;
  logic        gate_prev = 1'b0;
  int          n_fail = 0, n_tests = 0, n_rise = 0, on_len = 0, gap = 0;
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  lbbc_core #(.BLANK_CNT(BLANK), .PERIOD_CNT(PERIOD)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .supply_startup_i(startup),
    .supply_lockout_i(flt[3]), .dim_high_i(dim_high), .dim_open_i(flt[0]),
    .mask_high_i(mask_high), .mask_open_i(flt[1]), .sense_peak_i(peak),
    .short_circuit_trip_i(short_trip), .valley_i(valley), .over_temp_i(flt[2]),
    .gate_o(gate), .running_o(running), .short_fault_o(short_fault), .fault_o(fault));
  lbbc_load u_load (
    .sys_clk_i(sys_clk_i), .gate_i(gate), .charge_len_i(charge_len), .ring_len_i(ring_len),
    .mask_stuck_i(mask_stuck), .sense_peak_o(peak), .mask_high_o(mask_high),
    .valley_o(valley), .valley_age_o(valley_age));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // longest legal on time: blanking or the load's trip, plus sync and register delay
  function automatic int on_bound(input logic [7:0] c);
    return ((c > BLANK) ? int'(c) : BLANK) + 4;
  endfunction : on_bound
  task automatic final_report();
    $display("counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
      n_fail++;
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  task automatic wait_rises(input int k);
    int target;
    target = n_rise + k;
    for (int i = 0; i < 3000 && n_rise < target; i++) @(posedge sys_clk_i);
    if (n_rise < target) begin
      $display("wrong value gate rises expected %0d seen %0d", target, n_rise);
      n_fail++;
      final_report();
    end
  endtask : wait_rises
  // let a running cycle finish, then no turn-on may appear for a long stretch
  task automatic check_stopped(input logic exp_fault);
    int r;
    cyc(30);
    r = n_rise;
    cyc(60);
    check("rises while stopped", 8'(r), 8'(n_rise));
    check("gate while stopped", 8'h00, {7'h00, gate});
    check("fault flag", {7'h00, exp_fault}, {7'h00, fault});
  endtask : check_stopped
  // edge monitor: rises and falls are seen one edge late, so lengths stay exact
  always @(posedge sys_clk_i) begin
    gate_prev <= gate;
    gap       <= gap + 1;
    on_len    <= on_len + 1;
    if (gate === 1'b1 && gate_prev === 1'b0) begin
      n_rise   <= n_rise + 1;
      gap      <= 1;
      on_len   <= 1;
      in_cycle <= 1'b0;
      if (watch) check("turn-on spacing", 8'h01, {7'h00, gap >= PERIOD});
      if (watch && in_cycle) check("valley before on", 8'h01, {7'h00, valley_age != 0});
    end
    if (gate === 1'b0 && gate_prev === 1'b1) begin
      in_cycle <= watch;
      if (watch) check("on time floor", 8'h01, {7'h00, on_len >= BLANK});
      if (watch) check("on time ceiling", 8'h01, {7'h00, on_len <= on_bound(charge_len)});
    end
  end
  initial begin
    lfsr = 16'h000d;
    {startup, short_trip, dim_high, mask_stuck, watch, flt} = '0;
    charge_len = 8'h05;
    ring_len   = 8'h04;
    rst_n_i    = 1'b0;
    cyc(4);
    rst_n_i <= 1'b1;
    cyc(1);
    check("gate after reset", 8'h00, {7'h00, gate});
    check("running after reset", 8'h00, {7'h00, running});
    $display("test reset done");
    startup <= 1'b1;
    wait_rises(1);
    check("running", 8'h01, {7'h00, running});
    $display("test startup done");
    for (int i = 0; i < 8; i++) begin
      watch <= 1'b0;
      dim_high <= 1'b1;
      check_stopped(1'b0);
      lfsr = lfsr_next(lfsr);
      charge_len <= (i == 0) ? 8'h01 : {4'h0, lfsr[3:0]} + 8'h01;
      ring_len   <= {4'h0, lfsr[7:4]} + 8'h01;
      dim_high   <= 1'b0;
      wait_rises(1);
      watch <= 1'b1;
      wait_rises(3);
    end
    $display("test dimming cycles done");
    mask_stuck <= 1'b1;
    check_stopped(1'b0);
    mask_stuck <= 1'b0;
    wait_rises(2);
    watch <= 1'b0;
    $display("test masking done");
    for (int k = 0; k < 4; k++) begin
      flt[k]  <= 1'b1;
      startup <= (k != 3);
      check_stopped(k != 3);
      flt[k] <= 1'b0;
      if (k == 3) begin
        check_stopped(1'b0);
        startup <= 1'b1;
      end
      wait_rises(1);
    end
    $display("test faults done");
    short_trip <= 1'b1;
    cyc(4);
    short_trip <= 1'b0;
    check_stopped(1'b1);
    check("short latch", 8'h01, {7'h00, short_fault});
    flt[3]  <= 1'b1;
    startup <= 1'b0;
    cyc(6);
    flt[3]  <= 1'b0;
    startup <= 1'b1;
    wait_rises(1);
    check("short latch cleared", 8'h00, {7'h00, short_fault});
    $display("test short circuit done");
    final_report();
  end
endmodule : lbbc_bench
